// ### hdl/sowdt_top.sv
// watchdog with power-led control behind an index/data configuration port
// assumes host i/o cycles arrive as one-cycle strobes synchronous to CLK_SYS
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Two back-to-back writes of 87h to port 2Eh from wait-for-key open configuration mode.
// - While open, port 2Eh holds the register index and port 2Fh carries register data.
// - One write of 0aah to the index port closes configuration mode.
// - Index 07h selects the logical device and non-global accesses go to that device.
// - Mode bits 7-5 set the power led to high, low or a 50% blink at a chosen rate.
// - Mode bit 3 selects seconds when clear and minutes when set as the counting unit.
// - Mode bit 4 makes the counting unit 1000 times shorter.
// - With mode bit 2 set, a rising edge of the controller reset line forces a timeout.
// - With mode bit 1 set, every timeout sends a low pulse out on the keyboard reset pin.
// - Count 0 stops the counter so only forced timeouts occur, and count N times out after N units.
// - With control bit 7 set, a mouse interrupt reloads the counter.
// - With control bit 6 set, a keyboard interrupt reloads the counter.
// - Writing one to control bit 5 forces a timeout and the bit never stays set.
// - Control bit 4 reads one after a timeout and stays set until software writes it to zero.
// - Control bits 3-0 pick the timeout interrupt line, with 2 meaning the management line.
module sowdt_top (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // host i/o port
    input wire sowdt_pkg::sowdt_io_t IO_REQ,
    output logic [7:0] IO_RDATA,
    output logic IO_RVALID,
    // system events
    input wire sowdt_pkg::sowdt_evt_t EVT_IN,
    // outputs
    output logic WATCHDOG_TIMEOUT_OUT_N,
    output logic POWER_LED_OUTPUT,
    output logic KEYBOARD_RESET_PIN_N,
    output logic WDT_IRQ,
    output logic [3:0] WDT_IRQ_SEL,
    output logic SYSTEM_MANAGEMENT_INTERRUPT
);
    sowdt_pkg::sowdt_cfg_t cfg_r;
    logic [7:0] index_r;
    logic [7:0] dev_num_r;
    logic [7:0] mode_r;
    logic [7:0] count_r;
    logic mouse_en_r;
    logic kbd_en_r;
    logic status_r;
    logic [3:0] irq_sel_r;
    logic [7:0] cnt_r;
    logic [15:0] unit_r;
    logic running_r;
    logic kbc_d_r;
    logic [7:0] pulse_r;
    logic [7:0] rdata_nxt;
    logic ms_tick;
    logic idx_wr;
    logic dat_wr;
    logic dat_rd;
    logic wdt_sel;
    logic wr_count;
    logic wr_ctrl;
    logic reload;
    logic force_to;
    logic unit_done;
    logic count_out;
    logic timeout;
    logic [15:0] unit_len;

    // ==========================================================
    // port decode
    assign idx_wr = IO_REQ.wr && IO_REQ.addr == sowdt_pkg::PORT_INDEX;
    assign dat_wr = IO_REQ.wr && IO_REQ.addr == sowdt_pkg::PORT_DATA
        && cfg_r == sowdt_pkg::CFG_OPEN;
    assign dat_rd = IO_REQ.rd && IO_REQ.addr == sowdt_pkg::PORT_DATA
        && cfg_r == sowdt_pkg::CFG_OPEN;
    assign wdt_sel = dev_num_r == sowdt_pkg::WDT_DEV_NUM;
    assign wr_count = dat_wr && wdt_sel && index_r == sowdt_pkg::IDX_COUNT;
    assign wr_ctrl = dat_wr && wdt_sel && index_r == sowdt_pkg::IDX_CTRL;

    // ==========================================================
    // key sequence; any other index write breaks a half-entered key
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r <= sowdt_pkg::CFG_WAIT;
        end else if (idx_wr) begin
            unique case (cfg_r)
                sowdt_pkg::CFG_WAIT:
                    cfg_r <= (IO_REQ.data == sowdt_pkg::KEY_ENTER) ?
                        sowdt_pkg::CFG_KEY1 : sowdt_pkg::CFG_WAIT;
                sowdt_pkg::CFG_KEY1:
                    cfg_r <= (IO_REQ.data == sowdt_pkg::KEY_ENTER) ?
                        sowdt_pkg::CFG_OPEN : sowdt_pkg::CFG_WAIT;
                sowdt_pkg::CFG_OPEN:
                    if (IO_REQ.data == sowdt_pkg::KEY_EXIT) begin
                        cfg_r <= sowdt_pkg::CFG_WAIT;
                    end
                default: cfg_r <= sowdt_pkg::CFG_WAIT;
            endcase
        end else if (IO_REQ.wr && IO_REQ.addr != sowdt_pkg::PORT_DATA
                     && cfg_r == sowdt_pkg::CFG_KEY1) begin
            cfg_r <= sowdt_pkg::CFG_KEY1;
        end
    end

    // ==========================================================
    // index latch, only while open
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            index_r <= sowdt_pkg::RESET_BYTE;
        end else if (idx_wr && cfg_r == sowdt_pkg::CFG_OPEN
                     && IO_REQ.data != sowdt_pkg::KEY_EXIT) begin
            index_r <= IO_REQ.data;
        end
    end

    // ==========================================================
    // logical device number, global
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dev_num_r <= sowdt_pkg::RESET_BYTE;
        end else if (dat_wr && index_r == sowdt_pkg::IDX_DEV_SEL) begin
            dev_num_r <= IO_REQ.data;
        end
    end

    // ==========================================================
    // mode register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= sowdt_pkg::RESET_BYTE;
        end else if (dat_wr && wdt_sel && index_r == sowdt_pkg::IDX_MODE) begin
            mode_r <= IO_REQ.data;
        end
    end

    // ==========================================================
    // timeout count register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            count_r <= sowdt_pkg::RESET_BYTE;
        end else if (wr_count) begin
            count_r <= IO_REQ.data;
        end
    end

    // ==========================================================
    // control register; force bit is write only and never stored
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mouse_en_r <= 1'b0;
            kbd_en_r <= 1'b0;
            irq_sel_r <= 4'h0;
        end else if (wr_ctrl) begin
            mouse_en_r <= IO_REQ.data[sowdt_pkg::CTRL_MOUSE];
            kbd_en_r <= IO_REQ.data[sowdt_pkg::CTRL_KBD];
            irq_sel_r <= IO_REQ.data[sowdt_pkg::CTRL_IRQ_HI:0];
        end
    end

    // status flag: a timeout in the same cycle as a software clear wins
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            status_r <= 1'b0;
        end else if (timeout) begin
            status_r <= 1'b1;
        end else if (wr_ctrl) begin
            status_r <= IO_REQ.data[sowdt_pkg::CTRL_STATUS];
        end
    end

    // ==========================================================
    // event sources
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            kbc_d_r <= 1'b0;
        end else begin
            kbc_d_r <= EVT_IN.kbc_reset;
        end
    end

    assign force_to = (wr_ctrl && IO_REQ.data[sowdt_pkg::CTRL_FORCE])
        || (mode_r[sowdt_pkg::MODE_KBC_EDGE] && EVT_IN.kbc_reset && !kbc_d_r);
    assign reload = (mouse_en_r && EVT_IN.mouse_irq)
        || (kbd_en_r && EVT_IN.kbd_irq);

    // ==========================================================
    // unit prescaler: ms ticks per unit
    always_comb begin
        unique case ({mode_r[sowdt_pkg::MODE_FAST], mode_r[sowdt_pkg::MODE_MINUTE]})
            2'b00: unit_len = 16'(sowdt_pkg::UNITS_PER_SEC);
            2'b01: unit_len = 16'(sowdt_pkg::UNITS_PER_SEC * sowdt_pkg::SEC_PER_MIN);
            2'b10: unit_len = 16'h0001;
            2'b11: unit_len = 16'(sowdt_pkg::SEC_PER_MIN);
        endcase
    end

    assign unit_done = running_r && ms_tick && unit_r >= unit_len - 16'h0001;
    assign count_out = unit_done && cnt_r == 8'h01;
    assign timeout = count_out || force_to;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            unit_r <= 16'h0000;
        end else if (wr_count || reload || !running_r || unit_done) begin
            unit_r <= 16'h0000;
        end else if (ms_tick) begin
            unit_r <= unit_r + 16'h0001;
        end
    end

    // ==========================================================
    // down-counter
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= 8'h00;
            running_r <= 1'b0;
        end else if (wr_count) begin
            cnt_r <= IO_REQ.data;
            running_r <= IO_REQ.data != 8'h00;
        end else if (timeout) begin
            cnt_r <= 8'h00;
            running_r <= 1'b0;
        end else if (reload && running_r) begin
            cnt_r <= count_r;
        end else if (unit_done) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // ==========================================================
    // timeout pulse shared by the timeout and keyboard reset pins
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pulse_r <= 8'h00;
        end else if (timeout) begin
            pulse_r <= 8'(sowdt_pkg::PULSE_CYCLES);
        end else if (pulse_r != 8'h00) begin
            pulse_r <= pulse_r - 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            WATCHDOG_TIMEOUT_OUT_N <= 1'b1;
            KEYBOARD_RESET_PIN_N <= 1'b1;
        end else begin
            WATCHDOG_TIMEOUT_OUT_N <= !(timeout || pulse_r > 8'h01);
            KEYBOARD_RESET_PIN_N <= !(mode_r[sowdt_pkg::MODE_KB_RESET_EN]
                && (timeout || pulse_r > 8'h01));
        end
    end

    // ==========================================================
    // interrupt routing: level follows the status flag
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            WDT_IRQ <= 1'b0;
            SYSTEM_MANAGEMENT_INTERRUPT <= 1'b0;
        end else begin
            WDT_IRQ <= status_r && irq_sel_r != sowdt_pkg::IRQ_SEL_MGMT
                && irq_sel_r != 4'h0;
            SYSTEM_MANAGEMENT_INTERRUPT <= status_r
                && irq_sel_r == sowdt_pkg::IRQ_SEL_MGMT;
        end
    end
    assign WDT_IRQ_SEL = irq_sel_r;

    // ==========================================================
    // read path
    always_comb begin
        rdata_nxt = 8'h00;
        if (index_r == sowdt_pkg::IDX_DEV_SEL) begin
            rdata_nxt = dev_num_r;
        end else if (wdt_sel) begin
            unique case (index_r)
                sowdt_pkg::IDX_MODE: rdata_nxt = mode_r;
                sowdt_pkg::IDX_COUNT: rdata_nxt = count_r;
                sowdt_pkg::IDX_CTRL: rdata_nxt = {mouse_en_r, kbd_en_r, 1'b0,
                    status_r, irq_sel_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IO_RDATA <= 8'h00;
            IO_RVALID <= 1'b0;
        end else begin
            IO_RDATA <= dat_rd ? rdata_nxt : 8'h00;
            IO_RVALID <= dat_rd;
        end
    end

    // ==========================================================
    // time base and led
    sowdt_tick u_tick (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .led_mode(mode_r[sowdt_pkg::MODE_LED_HI:sowdt_pkg::MODE_LED_LO]),
        .ms_tick(ms_tick),
        .led_out(POWER_LED_OUTPUT)
    );
endmodule : sowdt_top
`default_nettype wire

// ### hdl/sowdt_pkg.sv
// package for the super i/o watchdog and power-led block
// assumes a 40 MHz system clock and an 8-bit i/o port interface from the host
package sowdt_pkg;

    // ==========================================================
    // i/o ports and keys
    localparam logic [7:0] PORT_INDEX = 8'h2e;
    localparam logic [7:0] PORT_DATA = 8'h2f;
    localparam logic [7:0] KEY_ENTER = 8'h87;
    localparam logic [7:0] KEY_EXIT = 8'haa;

    // ==========================================================
    // configuration indices
    localparam logic [7:0] IDX_DEV_SEL = 8'h07;
    localparam logic [7:0] IDX_MODE = 8'hf5;
    localparam logic [7:0] IDX_COUNT = 8'hf6;
    localparam logic [7:0] IDX_CTRL = 8'hf7;
    // logical device that holds the watchdog; value arbitrary
    localparam logic [7:0] WDT_DEV_NUM = 8'h08;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ==========================================================
    // field positions
    localparam int MODE_LED_HI = 7;
    localparam int MODE_LED_LO = 5;
    localparam int MODE_FAST = 4;
    localparam int MODE_MINUTE = 3;
    localparam int MODE_KBC_EDGE = 2;
    localparam int MODE_KB_RESET_EN = 1;
    localparam int CTRL_MOUSE = 7;
    localparam int CTRL_KBD = 6;
    localparam int CTRL_FORCE = 5;
    localparam int CTRL_STATUS = 4;
    localparam int CTRL_IRQ_HI = 3;
    localparam logic [3:0] IRQ_SEL_MGMT = 4'h2;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS_NS = 1_000_000;
    // one fast unit is 1 ms; a second is 1000 of them
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int UNITS_PER_SEC = 1000;
    localparam int SEC_PER_MIN = 60;
    // keyboard-reset pulse width
    localparam int RESET_PULSE_NS = 1000;
    localparam int PULSE_CYCLES = (RESET_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    // led half periods in ms: 4Hz, 2Hz, 1Hz, 0.5Hz, 0.25Hz
    localparam int HALF_4HZ_MS = 125;
    localparam int HALF_2HZ_MS = 250;
    localparam int HALF_1HZ_MS = 500;
    localparam int HALF_05HZ_MS = 1000;
    localparam int HALF_025HZ_MS = 2000;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        CFG_WAIT = 2'b00,
        CFG_KEY1 = 2'b01,
        CFG_OPEN = 2'b10
    } sowdt_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } sowdt_io_t;

    typedef struct packed {
        logic kbd_irq;
        logic mouse_irq;
        logic kbc_reset;
    } sowdt_evt_t;

endpackage : sowdt_pkg

// ### hdl/sowdt_tick.sv
// millisecond tick and led blink generator
// assumes the shared 40 MHz clock; one pulse per millisecond
`timescale 1ns/1ps
`default_nettype none
module sowdt_tick (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // led mode field
    input wire logic [2:0] led_mode,
    // outputs
    output logic ms_tick,
    output logic led_out
);
    logic [15:0] pre_r;
    logic [11:0] ms_r;
    logic [11:0] half_ms;

    // ==========================================================
    // prescaler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 16'h0000;
        end else if (pre_r == 16'(sowdt_pkg::MS_CYCLES - 1)) begin
            pre_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 16'h0001;
        end
    end
    assign ms_tick = (pre_r == 16'(sowdt_pkg::MS_CYCLES - 1));

    // ==========================================================
    // blink half period; all rates share one 50% toggle
    always_comb begin
        unique case (led_mode)
            3'b001: half_ms = 12'(sowdt_pkg::HALF_05HZ_MS);
            3'b011: half_ms = 12'(sowdt_pkg::HALF_2HZ_MS);
            3'b100: half_ms = 12'(sowdt_pkg::HALF_1HZ_MS);
            3'b101: half_ms = 12'(sowdt_pkg::HALF_4HZ_MS);
            3'b110, 3'b111: half_ms = 12'(sowdt_pkg::HALF_025HZ_MS);
            3'b000, 3'b010: half_ms = 12'(sowdt_pkg::HALF_1HZ_MS);
        endcase
    end

    logic blink_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_r <= 12'h000;
            blink_r <= 1'b0;
        end else if (ms_tick) begin
            if (ms_r >= half_ms - 12'h001) begin
                ms_r <= 12'h000;
                blink_r <= ~blink_r;
            end else begin
                ms_r <= ms_r + 12'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_out <= 1'b1;
        end else begin
            unique case (led_mode)
                3'b000: led_out <= 1'b1;
                3'b010: led_out <= 1'b0;
                default: led_out <= blink_r;
            endcase
        end
    end
endmodule : sowdt_tick
`default_nettype wire

// ### verif/sowdt_assertions.sv
// concurrent checks on the ports of the watchdog and power-led block
// assumes binding to sowdt_top; one clock domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sowdt_assertions (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // host i/o port
    input wire sowdt_pkg::sowdt_io_t IO_REQ,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_RVALID,
    // outputs
    input wire logic WATCHDOG_TIMEOUT_OUT_N,
    input wire logic KEYBOARD_RESET_PIN_N,
    input wire logic WDT_IRQ,
    input wire logic [3:0] WDT_IRQ_SEL,
    input wire logic SYSTEM_MANAGEMENT_INTERRUPT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // ==========================================================
    // pulse length counter
    logic [7:0] low_cnt_r;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            low_cnt_r <= 8'h00;
        end else if (WATCHDOG_TIMEOUT_OUT_N) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end

    // ==========================================================
    // checks
    sequence pulse_start_s;
        $fell(WATCHDOG_TIMEOUT_OUT_N) ##0 (WDT_IRQ_SEL != 4'h0);
    endsequence
    sequence irq_seen_s;
        ##[0:2] (WDT_IRQ || SYSTEM_MANAGEMENT_INTERRUPT);
    endsequence

    rdata_idle_a: assert property (!IO_RVALID |-> IO_RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    rvalid_cause_a: assert property (IO_RVALID |->
        $past(IO_REQ.rd) && $past(IO_REQ.addr) == sowdt_pkg::PORT_DATA)
        else $error("read answer without a data port read");
    pulse_len_a: assert property ($rose(WATCHDOG_TIMEOUT_OUT_N) |->
        low_cnt_r == 8'(sowdt_pkg::PULSE_CYCLES))
        else $error("timeout pulse has wrong width");
    pulse_max_a: assert property (low_cnt_r <= 8'(sowdt_pkg::PULSE_CYCLES))
        else $error("timeout pulse too long");
    keyboard_reset_pin_follow_a: assert property (!KEYBOARD_RESET_PIN_N |-> !WATCHDOG_TIMEOUT_OUT_N)
        else $error("keyboard reset low without timeout pulse");
    timeout_irq_a: assert property (pulse_start_s |-> irq_seen_s)
        else $error("timeout raised no interrupt");
    irq_route_a: assert property (WDT_IRQ && $stable(WDT_IRQ_SEL) |->
        WDT_IRQ_SEL != 4'h0 && WDT_IRQ_SEL != sowdt_pkg::IRQ_SEL_MGMT)
        else $error("irq with a select of none or management");
    mgmt_route_a: assert property (SYSTEM_MANAGEMENT_INTERRUPT && $stable(WDT_IRQ_SEL) |->
        WDT_IRQ_SEL == sowdt_pkg::IRQ_SEL_MGMT)
        else $error("management interrupt without its select");
    sel_hold_a: assert property (!IO_REQ.wr |=> $stable(WDT_IRQ_SEL))
        else $error("irq select moved without a write");
endmodule : sowdt_assertions

bind sowdt_top sowdt_assertions chk (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .IO_REQ(IO_REQ),
    .IO_RDATA(IO_RDATA),
    .IO_RVALID(IO_RVALID),
    .WATCHDOG_TIMEOUT_OUT_N(WATCHDOG_TIMEOUT_OUT_N),
    .KEYBOARD_RESET_PIN_N(KEYBOARD_RESET_PIN_N),
    .WDT_IRQ(WDT_IRQ),
    .WDT_IRQ_SEL(WDT_IRQ_SEL),
    .SYSTEM_MANAGEMENT_INTERRUPT(SYSTEM_MANAGEMENT_INTERRUPT)
);
`default_nettype wire

// ### verif/sowdt_host.sv
// host processor model issuing i/o port cycles
// assumes one-cycle strobes launched on the falling edge
`timescale 1ns/1ps
`default_nettype none
module sowdt_host (
    // clock
    input wire logic clk,
    // i/o port
    output var sowdt_pkg::sowdt_io_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid
);
    initial io_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, data: 8'hff};

    // released lines show the inverse, so stale data is never taken for fresh
    task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic g, output logic [7:0] q);
        @(negedge clk);
        io_req <= '{wr: w, rd: !w, addr: a, data: d};
        @(negedge clk);
        g = io_rvalid;
        q = io_rdata;
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask : cycle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic g;
        logic [7:0] q;
        cycle(1'b1, a, d, g, q);
    endtask : wr

    task automatic unlock();
        wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::KEY_ENTER);
        wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::KEY_ENTER);
    endtask : unlock

    task automatic lock();
        wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::KEY_EXIT);
    endtask : lock

    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
        wr(sowdt_pkg::PORT_INDEX, i);
        wr(sowdt_pkg::PORT_DATA, d);
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] i, output logic g, output logic [7:0] q);
        wr(sowdt_pkg::PORT_INDEX, i);
        cycle(1'b0, sowdt_pkg::PORT_DATA, 8'h00, g, q);
    endtask : cfg_rd

    task automatic pick_dev(input logic [7:0] n);
        cfg_wr(sowdt_pkg::IDX_DEV_SEL, n);
    endtask : pick_dev
endmodule : sowdt_host
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the watchdog and power-led block
// assumes sowdt_host drives the port; events driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, rst_n, g, rvalid, to_n, led, kb_n, irq, mgmt;
    logic [7:0] q, v, rdata;
    logic [3:0] sel;
    sowdt_pkg::sowdt_io_t io_req;
    sowdt_pkg::sowdt_evt_t evt;
    int miscompares, cmp_count, n, k;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    sowdt_top dut (
        .CLK_SYS(clk_sys),
        .RST_N(rst_n),
        .IO_REQ(io_req),
        .IO_RDATA(rdata),
        .IO_RVALID(rvalid),
        .EVT_IN(evt),
        .WATCHDOG_TIMEOUT_OUT_N(to_n),
        .POWER_LED_OUTPUT(led),
        .KEYBOARD_RESET_PIN_N(kb_n),
        .WDT_IRQ(irq),
        .WDT_IRQ_SEL(sel),
        .SYSTEM_MANAGEMENT_INTERRUPT(mgmt)
    );
    sowdt_host host (.clk(clk_sys), .io_req(io_req), .io_rdata(rdata), .io_rvalid(rvalid));

    // ==========================================================
    // helpers
    function automatic logic exp_led(input logic [7:0] m);
        return m[7:5] != 3'b010;
    endfunction : exp_led

    // force bit never reads back; status reflects whether a timeout fired
    function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic f);
        return (w & 8'hcf) | (f ? 8'h10 : 8'h00);
    endfunction : exp_ctrl

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wait_low(input int lim, output int c);
        c = 0;
        while (to_n !== 1'b0 && c < lim) begin
            @(negedge clk_sys);
            c++;
        end
    endtask : wait_low

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        evt = '0;
        v = 8'($urandom(50898));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        chk("led_rst", 1, led);
        chk("to_rst", 1, to_n);
        chk("kb_rst", 1, kb_n);
        // a foreign index write between the keys must keep the port locked
        host.wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::KEY_ENTER);
        host.wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::IDX_DEV_SEL);
        host.wr(sowdt_pkg::PORT_INDEX, sowdt_pkg::KEY_ENTER);
        host.cfg_rd(sowdt_pkg::IDX_MODE, g, q);
        chk("locked", 0, g);
        host.unlock();
        host.pick_dev(8'h03);
        host.cfg_wr(sowdt_pkg::IDX_MODE, 8'h40);
        host.cfg_rd(sowdt_pkg::IDX_MODE, g, q);
        chk("other_ldn", 0, q);
        chk("led_kept", 1, led);
        host.pick_dev(sowdt_pkg::WDT_DEV_NUM);
        for (n = 0; n < 3; n++) begin
            host.cfg_rd(sowdt_pkg::IDX_MODE + n[7:0], g, q);
            chk("rvalid", 1, g);
            chk("reset_val", sowdt_pkg::RESET_BYTE, q);
        end
        for (n = 0; n < 6; n++) begin
            evt = 3'($urandom) & 3'b110;
            v = 8'($urandom) & 8'h4b;
            host.cfg_wr(sowdt_pkg::IDX_MODE, v);
            host.cfg_rd(sowdt_pkg::IDX_MODE, g, q);
            chk("mode", v, q);
            chk("led", exp_led(v), led);
            v = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'($urandom);
            host.cfg_wr(sowdt_pkg::IDX_COUNT, v);
            host.cfg_rd(sowdt_pkg::IDX_COUNT, g, q);
            chk("count", v, q);
        end
        evt = '0;
        host.cfg_wr(sowdt_pkg::IDX_COUNT, 8'h00);
        host.cfg_wr(sowdt_pkg::IDX_MODE, 8'h02);
        host.cfg_wr(sowdt_pkg::IDX_CTRL, 8'h22);
        repeat (2) @(negedge clk_sys);
        chk("force_to", 0, to_n);
        chk("force_kb", 0, kb_n);
        chk("mgmt", 1, mgmt);
        chk("sel", {4'h0, sowdt_pkg::IRQ_SEL_MGMT}, {4'h0, sel});
        chk("no_irq", 0, irq);
        host.cfg_rd(sowdt_pkg::IDX_CTRL, g, q);
        chk("ctrl_forced", exp_ctrl(8'h22, 1), q);
        repeat (50) @(negedge clk_sys);
        chk("pulse_end", 1, to_n);
        host.cfg_wr(sowdt_pkg::IDX_CTRL, 8'h05);
        for (k = 0; k < 2; k++) begin
            host.cfg_wr(sowdt_pkg::IDX_MODE, k ? 8'h04 : 8'h00);
            evt.kbc_reset = 1'b1;
            wait_low(10, n);
            chk("edge_to", k, n < 10);
            chk("kb_off", 1, kb_n);
            repeat (3) @(negedge clk_sys);
            chk("edge_irq", k, irq);
            evt.kbc_reset = 1'b0;
            host.cfg_rd(sowdt_pkg::IDX_CTRL, g, q);
            chk("ctrl_edge", exp_ctrl(8'h05, k[0]), q);
        end
        repeat (50) @(negedge clk_sys);
        host.cfg_wr(sowdt_pkg::IDX_CTRL, 8'h05);
        host.cfg_wr(sowdt_pkg::IDX_MODE, 8'h50);
        host.cfg_wr(sowdt_pkg::IDX_COUNT, 8'h01);
        host.cfg_rd(sowdt_pkg::IDX_CTRL, g, q);
        chk("counting", exp_ctrl(8'h05, 0), q);
        chk("led_low", exp_led(8'h50), led);
        wait_low(sowdt_pkg::MS_CYCLES + 100, n);
        chk("expired", 0, to_n);
        repeat (3) @(negedge clk_sys);
        chk("count_irq", 1, irq);
        host.lock();
        host.cfg_rd(sowdt_pkg::IDX_CTRL, g, q);
        chk("closed", 0, g);
        // reset in mid-run cuts the live pulse and drops the interrupt
        rst_n = 1'b0;
        @(negedge clk_sys) rst_n = 1'b1;
        chk("to_mid_rst", 1, to_n);
        chk("irq_mid_rst", 0, irq);
        close_out();
    end
endmodule : tb
`default_nettype wire
